// ### design/temp_alarm.sv
`timescale 1ns/1ps
`include "temp_alarm_regs.svh"
// Summary of operation
// - bus access aborts conversion, restart after transfer
// - data stuck low: abandon transfer, release line
// - stuck timeout disabled during shutdown
// - comparator: set above limit, clear below limit
// - shutdown keeps comparator alarm state
// - interrupt alarm latches until any read
// - after an above-limit trip, next trip is below limit
// - shutdown clears interrupt style alarm
// - power-up comparator, 80C, 75C, active low
// - address 1001 plus three select pins
// - values are 9-bit two's complement halves
// - interface and limits usable in shutdown
// - alarm after consecutive fault count up to six
// - polarity selectable, active low by default
// - alarm pin is open drain only
// - select resets to temperature, then retained
// - temperature and identity are read only
// - write: address, select, then data bytes
// - read: address only, or select then restart
// - read data msb byte first, msb bit first
// - master ack or nack both accepted
// - select codes 0,1,2,3,7; upper bits zero
// - config: shutdown, style, polarity, fault count
// - 9-bit value sits in word bits 15:7
// - stuck timeout between 75 and 325 ms
module temp_alarm #(
  parameter int unsigned TIMEOUT_CYC = `TMO_CYC, // stuck line timeout
  parameter logic [7:0] ID_CODE = 8'h5C // arbitrary identity value
) (
  input wire logic i_sys_clk, // core clock, 200 MHz
  input wire logic i_rst_n, // asynchronous reset, active low
  input wire logic i_bus_clk, // sampling clock of the serial link
  input wire logic i_scl, // serial clock pin
  input wire logic i_sda, // serial data pin, input side
  output logic o_sda_out, // serial data pin, output level
  output logic o_sda_oe, // serial data pin, pull low when high
  input wire logic i_addr_select_bit2, // address select pin 2
  input wire logic i_addr_select_bit1, // address select pin 1
  input wire logic i_addr_select_bit0, // address select pin 0
  output logic o_alarm_out, // alarm pin, output level
  output logic o_alarm_oe, // alarm pin, pull low when high
  input wire logic [8:0] i_conv_result, // converter result
  input wire logic i_conv_done, // converter done strobe
  output logic o_conv_run // converter may run
);

  // fault count code to number of faults
  function automatic logic [2:0] fq_need(input logic [1:0] code);
    case (code)
      2'h0: fq_need = 3'h1;
      2'h1: fq_need = 3'h2;
      2'h2: fq_need = 3'h4;
      default: fq_need = 3'h6;
    endcase
  endfunction

  // ---------------- link side ----------------
  logic [4:0] pin_in; // {select pins, scl, sda}
  logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q; // pin synchroniser
  logic [4:0] pin_f_q, pin_f_d; // agreed pin levels
  logic [4:0] pin_p_q; // agreed levels one cycle back
  logic [1:0] ln_s1_q, ln_s2_q, ln_s3_q; // {temp, timeout} toggles
  temp_alarm_pkg::bus_state_t st_q; // engine state
  logic [3:0] bit_q; // bit counter
  logic [7:0] sh_q; // shift register
  logic [7:0] msb_q; // first limit byte
  logic [1:0] idx_q; // byte index within transfer
  logic rw_q; // transfer direction, 1 is read
  logic nack_q; // master refused last byte
  logic oe_q; // data line pull
  logic [2:0] sel_q; // register select field
  logic [4:0] cfg_b_q; // configuration copy
  logic [8:0] set_b_q, clr_b_q; // limit copies
  logic [8:0] temp_b_q; // temperature copy
  logic cfg_tgl_q; // new settings toggle
  logic rd_tgl_q; // read toggle
  logic [8:0] temp_q; // last temperature, core side
  logic tmp_tgl_q, tmo_tgl_q; // events to the link side, core side
  logic busy_b_q; // engine busy, registered before crossing
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c; // bus events
  logic tmo_b, tmp_b; // events from the core
  logic [2:0] dev_sel; // agreed address select pins
  logic [7:0] rd_first; // first byte of a read
  logic [7:0] rd_next; // later byte of a read

  assign pin_in = {i_addr_select_bit2, i_addr_select_bit1,
                   i_addr_select_bit0, i_scl, i_sda};
  // a change counts once stages two and three agree
  assign pin_f_d = (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
  assign scl = pin_f_q[1];
  assign sda = pin_f_q[0];
  assign dev_sel = pin_f_q[4:2];
  assign scl_rise = scl & ~pin_p_q[1];
  assign scl_fall = ~scl & pin_p_q[1];
  assign start_c = scl & pin_p_q[1] & pin_p_q[0] & ~sda;
  assign stop_c = scl & pin_p_q[1] & ~pin_p_q[0] & sda;
  assign tmo_b = ln_s2_q[0] ^ ln_s3_q[0];
  assign tmp_b = ln_s2_q[1] ^ ln_s3_q[1];
  assign o_sda_out = 1'b0;
  assign o_sda_oe = oe_q;

  // read byte selection, msb byte first
  function automatic logic [7:0] rd_byte(input logic [2:0] sel,
                                         input logic lsb,
                                         input logic [8:0] t,
                                         input logic [4:0] c,
                                         input logic [8:0] h,
                                         input logic [8:0] s);
    case (sel)
      `SEL_TEMP: rd_byte = lsb ? {t[0], 7'h00} : t[8:1];
      `SEL_CFG: rd_byte = {3'h0, c};
      `SEL_CLR: rd_byte = lsb ? {h[0], 7'h00} : h[8:1];
      `SEL_SET: rd_byte = lsb ? {s[0], 7'h00} : s[8:1];
      `SEL_ID: rd_byte = ID_CODE;
      default: rd_byte = 8'h00;
    endcase
  endfunction

  assign rd_first = rd_byte(sel_q, 1'b0, temp_b_q, cfg_b_q, clr_b_q, set_b_q);
  assign rd_next = rd_byte(sel_q, idx_q[0], temp_b_q, cfg_b_q, clr_b_q,
                           set_b_q);

  // pin and toggle synchronisers
  always_ff @(posedge i_bus_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1_q <= 5'h03;
      pin_s2_q <= 5'h03;
      pin_s3_q <= 5'h03;
      pin_f_q <= 5'h03;
      pin_p_q <= 5'h03;
      ln_s1_q <= 2'h0;
      ln_s2_q <= 2'h0;
      ln_s3_q <= 2'h0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q <= pin_f_d;
      pin_p_q <= pin_f_q;
      ln_s1_q <= {tmp_tgl_q, tmo_tgl_q};
      ln_s2_q <= ln_s1_q;
      ln_s3_q <= ln_s2_q;
    end
  end

  // temperature copy follows each new core result
  always_ff @(posedge i_bus_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      temp_b_q <= 9'h000;
    end else if (tmp_b) begin
      temp_b_q <= temp_q;
    end
  end

  // serial slave engine
  always_ff @(posedge i_bus_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= temp_alarm_pkg::ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      msb_q <= 8'h00;
      idx_q <= 2'h0;
      rw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      sel_q <= `SEL_RST;
      cfg_b_q <= `CFG_RST;
      set_b_q <= `SET_RST;
      clr_b_q <= `CLR_RST;
      cfg_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
    end else if (tmo_b) begin
      // stuck line: drop the transfer and let go
      st_q <= temp_alarm_pkg::ST_IDLE;
      oe_q <= 1'b0;
    end else if (start_c) begin
      // start or repeated start
      st_q <= temp_alarm_pkg::ST_ADDR;
      bit_q <= 4'h0;
      idx_q <= 2'h0;
      oe_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= temp_alarm_pkg::ST_IDLE;
      oe_q <= 1'b0;
    end else begin
      case (st_q)
        temp_alarm_pkg::ST_ADDR, temp_alarm_pkg::ST_WR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (st_q == temp_alarm_pkg::ST_ADDR) begin
              // match 1001 and the select pins
              if (sh_q[7:1] == {`DEV_ADDR_HI, dev_sel}) begin
                st_q <= temp_alarm_pkg::ST_AACK;
                oe_q <= 1'b1;
                rw_q <= sh_q[0];
              end else begin
                st_q <= temp_alarm_pkg::ST_IDLE;
              end
            end else begin
              st_q <= temp_alarm_pkg::ST_WACK;
              oe_q <= 1'b1;
              idx_q <= idx_q + {1'b0, idx_q != 2'h3};
              // select byte first, then data
              if (idx_q == 2'h0) begin
                sel_q <= sh_q[2:0]; // upper bits dropped
              end else if (idx_q == 2'h1) begin
                msb_q <= sh_q;
                if (sel_q == `SEL_CFG) begin
                  cfg_b_q <= sh_q[4:0];
                  cfg_tgl_q <= ~cfg_tgl_q;
                end
              end else if (idx_q == 2'h2) begin
                // temperature and identity never written
                if (sel_q == `SEL_SET) begin
                  set_b_q <= {msb_q, sh_q[7]};
                  cfg_tgl_q <= ~cfg_tgl_q;
                end else if (sel_q == `SEL_CLR) begin
                  clr_b_q <= {msb_q, sh_q[7]};
                  cfg_tgl_q <= ~cfg_tgl_q;
                end
              end
            end
          end
        end
        temp_alarm_pkg::ST_AACK: begin
          if (scl_fall) begin
            bit_q <= 4'h0;
            if (rw_q) begin
              // read with the retained select
              st_q <= temp_alarm_pkg::ST_RD;
              sh_q <= rd_first;
              oe_q <= ~rd_first[7];
              idx_q <= 2'h1;
              rd_tgl_q <= ~rd_tgl_q;
            end else begin
              st_q <= temp_alarm_pkg::ST_WR;
              oe_q <= 1'b0;
            end
          end
        end
        temp_alarm_pkg::ST_WACK: begin
          if (scl_fall) begin
            st_q <= temp_alarm_pkg::ST_WR;
            oe_q <= 1'b0;
          end
        end
        temp_alarm_pkg::ST_RD: begin
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              st_q <= temp_alarm_pkg::ST_RACK;
              oe_q <= 1'b0;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6]; // msb bit first
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        temp_alarm_pkg::ST_RACK: begin
          if (scl_rise) begin
            nack_q <= sda;
          end else if (scl_fall) begin
            // ack or nack both fine
            bit_q <= 4'h0;
            if (nack_q) begin
              st_q <= temp_alarm_pkg::ST_IDLE;
            end else begin
              st_q <= temp_alarm_pkg::ST_RD;
              sh_q <= rd_next;
              oe_q <= ~rd_next[7];
              idx_q <= {1'b0, ~idx_q[0]};
            end
          end
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // busy flag from a flip-flop, so no state decode glitch crosses
  always_ff @(posedge i_bus_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_b_q <= 1'b0;
    end else begin
      busy_b_q <= st_q != temp_alarm_pkg::ST_IDLE;
    end
  end

  // ---------------- core side ----------------
  logic [3:0] cs_s1_q, cs_s2_q, cs_s3_q; // {sda, cfg, read, busy}
  logic sda_f_q; // agreed data line level
  logic [4:0] cfg_q; // configuration
  logic [8:0] set_q, clr_q; // limits
  logic act_q; // thermostat state
  logic int_q; // latched alarm
  logic [2:0] fcnt_q; // consecutive faults
  logic [25:0] tmo_cnt_q; // data low counter
  logic alarm_low_q; // alarm pin pulled low
  logic busy_s, cfg_evt, rd_evt, conv_take, fault, trip, alarm_act;
  logic [2:0] fcnt_inc;

  assign busy_s = cs_s2_q[0];
  assign rd_evt = cs_s2_q[1] ^ cs_s3_q[1];
  assign cfg_evt = cs_s2_q[2] ^ cs_s3_q[2];
  assign o_conv_run = ~cfg_q[`CFG_SD] & ~busy_s;
  assign conv_take = i_conv_done & o_conv_run;
  // signed compare of 9-bit values
  assign fault = act_q ? ($signed(i_conv_result) < $signed(clr_q))
                       : ($signed(i_conv_result) > $signed(set_q));
  assign fcnt_inc = fcnt_q + 3'h1;
  assign trip = conv_take & fault &
                (fcnt_inc >= fq_need(cfg_q[`CFG_FQ_HI:`CFG_FQ_LO]));
  assign alarm_act = cfg_q[`CFG_INT] ? int_q : act_q;
  assign o_alarm_out = 1'b0; // never driven high
  assign o_alarm_oe = alarm_low_q;

  // crossing from the link side
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_s1_q <= 4'h8;
      cs_s2_q <= 4'h8;
      cs_s3_q <= 4'h8;
      sda_f_q <= 1'b1;
    end else begin
      cs_s1_q <= {i_sda, cfg_tgl_q, rd_tgl_q, busy_b_q};
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      if (cs_s2_q[3] == cs_s3_q[3]) begin
        sda_f_q <= cs_s3_q[3];
      end
    end
  end

  // settings captured once the link side toggles
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_q <= `CFG_RST;
      set_q <= `SET_RST;
      clr_q <= `CLR_RST;
    end else if (cfg_evt) begin
      cfg_q <= cfg_b_q;
      set_q <= set_b_q;
      clr_q <= clr_b_q;
    end
  end

  // conversion results and fault filter
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      temp_q <= 9'h000;
      tmp_tgl_q <= 1'b0;
      fcnt_q <= 3'h0;
      act_q <= 1'b0;
    end else if (conv_take) begin
      temp_q <= i_conv_result;
      tmp_tgl_q <= ~tmp_tgl_q;
      if (trip) begin
        act_q <= ~act_q;
        fcnt_q <= 3'h0;
      end else begin
        fcnt_q <= fault ? fcnt_inc : 3'h0;
      end
    end
  end

  // latched alarm: a trip wins over a read or shutdown
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_q <= 1'b0;
    end else if (trip) begin
      int_q <= 1'b1;
    end else if (rd_evt || cfg_q[`CFG_SD]) begin
      int_q <= 1'b0;
    end
  end

  // alarm pin, inverted when active high selected
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alarm_low_q <= 1'b0;
    end else begin
      alarm_low_q <= alarm_act ^ cfg_q[`CFG_POL];
    end
  end

  // stuck data line counter, idle in shutdown
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmo_cnt_q <= 26'h0;
      tmo_tgl_q <= 1'b0;
    end else if (cfg_q[`CFG_SD] || sda_f_q) begin
      tmo_cnt_q <= 26'h0;
    end else if (tmo_cnt_q == 26'(TIMEOUT_CYC - 1)) begin
      tmo_cnt_q <= 26'h0;
      tmo_tgl_q <= ~tmo_tgl_q;
    end else begin
      tmo_cnt_q <= tmo_cnt_q + 26'h1;
    end
  end

  // ---------------- checks ----------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_pin_pol;
    ##1 o_alarm_oe == $past(alarm_act ^ cfg_q[`CFG_POL]);
  endproperty
  a_pin_pol: assert property (p_pin_pol)
    else $error("alarm pin level does not follow state and polarity");

  property p_od;
    o_alarm_out == 1'b0 && o_sda_out == 1'b0;
  endproperty
  a_od: assert property (p_od)
    else $error("open drain pin driven high");

  property p_abort;
    busy_s |-> !o_conv_run && !conv_take;
  endproperty
  a_abort: assert property (p_abort)
    else $error("conversion accepted during bus access");

  property p_rd_clr;
    rd_evt && !trip |=> !int_q;
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("latched alarm not cleared by read");

  property p_sd_clr;
    cfg_q[`CFG_SD] && !trip |=> !int_q;
  endproperty
  a_sd_clr: assert property (p_sd_clr)
    else $error("shutdown did not clear latched alarm");

  property p_cmp_keep;
    cfg_q[`CFG_SD] |=> $stable(act_q);
  endproperty
  a_cmp_keep: assert property (p_cmp_keep)
    else $error("shutdown changed thermostat state");

  property p_tmo_off;
    cfg_q[`CFG_SD] |=> tmo_cnt_q == 26'h0 && $stable(tmo_tgl_q);
  endproperty
  a_tmo_off: assert property (p_tmo_off)
    else $error("timeout counted in shutdown");

  property p_fq;
    conv_take && fault && !trip |=> fcnt_q == $past(fcnt_inc);
  endproperty
  a_fq: assert property (p_fq)
    else $error("fault counter did not advance");

  property p_trip;
    trip |=> fcnt_q == 3'h0 && act_q != $past(act_q);
  endproperty
  a_trip: assert property (p_trip)
    else $error("trip did not switch thermostat state");

  property p_temp;
    conv_take |=> temp_q == $past(i_conv_result);
  endproperty
  a_temp: assert property (p_temp)
    else $error("result not stored on done strobe");

  property p_ack;
    @(posedge i_bus_clk) disable iff (!i_rst_n)
      st_q == temp_alarm_pkg::ST_AACK |-> oe_q;
  endproperty
  a_ack: assert property (p_ack)
    else $error("address acknowledge not driven");

  c_trip: cover property (trip);
  c_rd_clr: cover property (int_q ##1 rd_evt ##1 !int_q);
  c_tmo: cover property (tmo_cnt_q == 26'(TIMEOUT_CYC - 1));
endmodule

// ### design/temp_alarm_pkg.sv
package temp_alarm_pkg;
  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, // waiting for a start
    ST_ADDR = 3'h1, // shifting the address byte
    ST_AACK = 3'h2, // acknowledging the address
    ST_WR = 3'h3, // shifting a written byte
    ST_WACK = 3'h4, // acknowledging a written byte
    ST_RD = 3'h5, // driving a read byte
    ST_RACK = 3'h6 // sampling the master acknowledge
  } bus_state_t;
endpackage

// ### design/temp_alarm_regs.svh
`ifndef TEMP_ALARM_REGS_SVH
`define TEMP_ALARM_REGS_SVH
// register select codes
`define SEL_TEMP 3'h0
`define SEL_CFG 3'h1
`define SEL_CLR 3'h2
`define SEL_SET 3'h3
`define SEL_ID 3'h7
// fixed upper bits of the 7-bit bus address
`define DEV_ADDR_HI 4'h9
// configuration field positions
`define CFG_SD 0
`define CFG_INT 1
`define CFG_POL 2
`define CFG_FQ_LO 3
`define CFG_FQ_HI 4
// reset values (0.5 degree steps: 80 C = 160, 75 C = 150)
`define CFG_RST 5'h00
`define SET_RST 9'h0A0
`define CLR_RST 9'h096
`define SEL_RST 3'h0
// stuck data line timeout
`define TMO_MIN_MS 75
`define TMO_MAX_MS 325
`define SYS_CLK_MHZ 200
`define TMO_CYC (`TMO_MIN_MS * 1000 * `SYS_CLK_MHZ)
`endif

// ### verification/i2c_master_model.sv
`timescale 1ns/1ps
// bus master model: open drain, only pulls lines low or releases them
module i2c_master_model (
  output logic o_scl_low, // pulls the serial clock low
  output logic o_sda_low, // pulls the serial data low
  input wire logic i_sda // resolved data line
);
  localparam int Q = 60; // quarter bit time in ns
  // both lines released until the first frame
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // start or repeated start, leaves the clock low
  task automatic start();
    o_sda_low = 1'b0;
    #Q o_scl_low = 1'b0;
    #Q o_sda_low = 1'b1;
    #Q o_scl_low = 1'b1;
    #Q;
  endtask
  // stop condition, ends with both lines released
  task automatic stop();
    o_sda_low = 1'b1;
    #Q o_scl_low = 1'b0;
    #Q o_sda_low = 1'b0;
    #Q;
  endtask
  // data set while clock low, sampled while clock high
  task automatic bit_slot(input logic b, output logic s);
    o_sda_low = ~b;
    #Q o_scl_low = 1'b0;
    #Q s = i_sda;
    #Q o_scl_low = 1'b1;
    #Q;
  endtask
  // byte out msb first, returns the acknowledge seen
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
    bit_slot(1'b1, s);
    ack = ~s;
  endtask
  // byte in msb first, then ack or nack
  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, s);
      d[i] = s;
    end
    bit_slot(~ack, s);
  endtask
  // holds data low with the clock low, a faulty master
  task automatic hold_low(input int ns);
    o_sda_low = 1'b1;
    #(ns);
    o_sda_low = 1'b0;
  endtask
endmodule

// ### verification/tb_temp_alarm.sv
`timescale 1ns/1ps
`include "temp_alarm_regs.svh"
// self-checking bench of the alarm sensor core
module tb_temp_alarm;
  localparam int TMO = 1000; // shortened stuck-line timeout
  localparam logic [7:0] ID = 8'h3C; // arbitrary identity value
  logic sys_clk, bus_clk, rst_n, conv_done, ack;
  logic scl_low, sda_low, sda_oe, sda_out;
  logic alarm_oe, alarm_out, conv_run;
  logic [8:0] conv_result, v;
  logic [2:0] pins; // address select pins
  logic [6:0] dev; // expected bus address
  logic [15:0] w; // last word read
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  wire scl = ~scl_low; // pulled up when released
  wire sda = ~(sda_low | sda_oe); // wired open drain

  temp_alarm #(.TIMEOUT_CYC(TMO), .ID_CODE(ID)) dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_bus_clk(bus_clk),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_addr_select_bit2(pins[2]), .i_addr_select_bit1(pins[1]),
    .i_addr_select_bit0(pins[0]), .o_alarm_out(alarm_out),
    .o_alarm_oe(alarm_oe), .i_conv_result(conv_result),
    .i_conv_done(conv_done), .o_conv_run(conv_run));

  i2c_master_model mst (.o_scl_low(scl_low), .o_sda_low(sda_low),
    .i_sda(sda));

  // core clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // link sampling clock, unrelated phase
  initial begin
    bus_clk = 1'b0;
    #1.3;
    forever #3 bus_clk = ~bus_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // 9-bit value placed in word bits 15:7
  function automatic logic [15:0] word(input logic [8:0] t);
    return {t, 7'h00};
  endfunction
  // fault count from its two-bit code
  function automatic int nf(input int q);
    case (q)
      0: return 1;
      1: return 2;
      2: return 4;
      default: return 6;
    endcase
  endfunction
  // alarm pin: pulled low when active and polarity low
  task automatic chk_al(input logic act, input logic pol);
    check(16'(alarm_oe), 16'(act ^ pol));
    check(16'(alarm_out), 16'h0000);
    check(16'(sda_out), 16'h0000);
  endtask
  task automatic wr(input logic [2:0] sel, input logic [15:0] d);
    mst.start();
    mst.send({dev, 1'b0}, ack);
    check(16'(ack), 16'h0001);
    mst.send({5'h00, sel}, ack);
    mst.send(d[15:8], ack);
    mst.send(d[7:0], ack);
    mst.stop();
  endtask
  // two-byte read, select written first when setp is high
  task automatic rd(input logic [2:0] sel, input logic setp);
    if (setp) begin
      mst.start();
      mst.send({dev, 1'b0}, ack);
      mst.send({5'h00, sel}, ack);
    end
    mst.start();
    mst.send({dev, 1'b1}, ack);
    mst.recv(1'b1, w[15:8]);
    mst.recv(1'b0, w[7:0]);
    mst.stop();
  endtask
  // one converter result with its done strobe
  task automatic conv(input logic [8:0] t);
    int k;
    k = 0;
    while (conv_run !== 1'b1 && k < 1000) begin
      @(negedge sys_clk);
      k++;
    end
    @(negedge sys_clk);
    conv_result = t;
    conv_done = 1'b1;
    @(negedge sys_clk);
    conv_done = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  // address, stuck data line, then a select byte
  task automatic stuck(input logic exp);
    mst.start();
    mst.send({dev, 1'b0}, ack);
    mst.hold_low(7000);
    mst.send(8'h01, ack);
    mst.stop();
    check(16'(ack), 16'(exp));
  endtask

  initial begin
    rst_n = 1'b0;
    conv_done = 1'b0;
    conv_result = 9'h000;
    void'($urandom(95038));
    pins = 3'($urandom);
    dev = {`DEV_ADDR_HI, pins};
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (20) @(negedge sys_clk);
    chk_al(1'b0, 1'b0);
    conv(9'h032);
    rd(`SEL_TEMP, 1'b0);
    check(w, word(9'h032));
    rd(`SEL_CFG, 1'b1);
    check(w, 16'h0000);
    rd(`SEL_SET, 1'b1);
    check(w, word(`SET_RST));
    rd(`SEL_CLR, 1'b1);
    check(w, word(`CLR_RST));
    // wrong address is ignored
    mst.start();
    mst.send({dev ^ 7'h01, 1'b0}, ack);
    mst.stop();
    check(16'(ack), 16'h0000);
    // converter held off while the bus is busy
    mst.start();
    mst.send({dev, 1'b0}, ack);
    check(16'(conv_run), 16'h0000);
    mst.stop();
    repeat (20) @(negedge sys_clk);
    check(16'(conv_run), 16'h0001);
    // read-only places keep their contents
    wr(`SEL_TEMP, 16'hFFFF);
    wr(`SEL_ID, 16'h0000);
    rd(`SEL_TEMP, 1'b1);
    check(w, word(9'h032));
    rd(`SEL_ID, 1'b1);
    check(w, {ID, ID});
    // random limits, read back with the retained select
    for (int i = 0; i < 4; i++) begin
      v = 9'($urandom);
      wr(i[0] ? `SEL_SET : `SEL_CLR, {v, 7'($urandom)});
      rd(3'h0, 1'b0);
      check(w, word(v));
    end
    // set 50 C, clear -5 C, so the compare must be signed
    wr(`SEL_SET, word(9'h064));
    wr(`SEL_CLR, word(9'h1F6));
    conv(9'h1EC);
    for (int q = 0; q < 4; q++) begin
      wr(`SEL_CFG, {2{3'h0, q[1:0], 3'h0}});
      repeat (nf(q) - 1) conv(9'h070);
      conv(9'h000);
      repeat (nf(q) - 1) conv(9'h070);
      chk_al(1'b0, 1'b0);
      conv(9'h070);
      chk_al(1'b1, 1'b0);
      repeat (nf(q)) conv(9'h000);
      chk_al(1'b1, 1'b0);
      repeat (nf(q)) conv(9'h1EC);
      chk_al(1'b0, 1'b0);
    end
    // shutdown keeps the thermostat output
    wr(`SEL_CFG, 16'h0000);
    conv(9'h070);
    wr(`SEL_CFG, 16'h0101);
    chk_al(1'b1, 1'b0);
    rd(`SEL_SET, 1'b1);
    check(w, word(9'h064));
    stuck(1'b1);
    wr(`SEL_CFG, 16'h0000);
    stuck(1'b0);
    conv(9'h1EC);
    chk_al(1'b0, 1'b0);
    // latched style
    wr(`SEL_CFG, 16'h0202);
    conv(9'h070);
    conv(9'h000);
    chk_al(1'b1, 1'b0);
    rd(`SEL_CFG, 1'b1);
    chk_al(1'b0, 1'b0);
    conv(9'h070);
    chk_al(1'b0, 1'b0);
    conv(9'h1EC);
    chk_al(1'b1, 1'b0);
    wr(`SEL_CFG, 16'h0303);
    chk_al(1'b0, 1'b0);
    // active-high polarity
    wr(`SEL_CFG, 16'h0404);
    chk_al(1'b0, 1'b1);
    conv(9'h070);
    chk_al(1'b1, 1'b1);
    print_verdict();
  end
endmodule
